// ==== hdl/pns_params.svh ====
// Register offsets, reset values and field positions for pattern staging
`ifndef PNS_PARAMS_SVH
`define PNS_PARAMS_SVH
// Next-data byte addresses are four times the register index
`define PNS_OFF_NEXT_HI     12'he90
`define PNS_OFF_NEXT_HI_ALT 12'he98
`define PNS_OFF_NEXT_LO     12'he94
`define PNS_OFF_NEXT_LO_ALT 12'he9c
`define PNS_IDX_NEXT_HI     16'hffa4
`define PNS_IDX_NEXT_HI_ALT 16'hffa6
`define PNS_IDX_NEXT_LO     16'hffa5
`define PNS_IDX_NEXT_LO_ALT 16'hffa7
`define PNS_OFF_EN_LO       12'hf00
`define PNS_OFF_EN_HI       12'hf04
`define PNS_OFF_TRIG        12'hf08
`define PNS_OFF_PORT        12'hf0c
`define PNS_RST_NEXT        8'h00
`define PNS_RST_EN          8'h00
`define PNS_RST_TRIG        8'hff
`define PNS_RST_PORT        8'h00
`define PNS_RSVD            8'hff
`define PNS_TRIG_G0         1
`define PNS_TRIG_G1         3
`define PNS_TRIG_G2         5
`define PNS_TRIG_G3         7
`endif

// ==== hdl/pns_pkg.sv ====
// Types shared by the pattern next-data staging block
package pns_pkg;
    typedef logic [7:0]  pns_byte_t;
    typedef logic [1:0]  pns_sel_t;
    typedef logic [31:0] pns_word_t;
    typedef enum logic [2:0] {
        PNS_IDLE   = 3'b001,
        PNS_SETUP  = 3'b010,
        PNS_ACCESS = 3'b100
    } pns_apb_state_t;
endpackage : pns_pkg

// ==== hdl/pns_staging.sv ====
// Pattern next-data staging with per-bit enables and port latches
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pns_params.svh"

// Function
// [RQ1] Upper-pair next data is an 8-bit read/write register for pins 15..8
// [RQ2] Group match copies upper next data into port B latch bits
// [RQ3] Upper next data clears on reset or hardware standby only
// [RQ4] Shared trigger: upper next data is one byte, group 3 high nibble
// [RQ5] Shared trigger: companion address ignores writes, reads all ones
// [RQ6] Separate triggers: group 3 at first address, group 2 at companion
// [RQ7] Separate triggers: unused nibbles ignore writes and read as ones
// [RQ8] Lower-pair enable is an 8-bit read/write register for pins 7..0
// [RQ9] Enabled lower bits copy next data into port A latch on match
// [RQ10] Disabled lower bits are not copied, port A output unchanged
// [RQ11] Lower enable clears on reset or hardware standby only
// [RQ12] Upper-pair enable is an 8-bit read/write register for pins 15..8
// [RQ13] Enabled upper bits copy next data into port B latch on match
// [RQ14] Disabled upper bits are skipped, port B output unchanged
// [RQ15] Upper enable clears on reset or hardware standby only
// [RQ16] Enabled port latch bits ignore software writes
// [RQ17] Software sets port B direction bits for used pattern pins
// [RQ18] Each group fires only on its own two-bit selected match
// [RQ19] Transfer on next edge after strobe, each group independent
module pns_staging (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              hw_standby,
    input  wire logic [3:0]        match_strobe,
    input  wire logic [7:0]        lower_next_bits,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic                   pslverr,
    output pns_pkg::pns_word_t     prdata,
    output pns_pkg::pns_byte_t     port_a_output_latch,
    output pns_pkg::pns_byte_t     port_b_output_latch
);
    import pns_pkg::*;

    pns_byte_t upper_next_q, upper_next_d;
    pns_byte_t lo_en_q, lo_en_d;
    pns_byte_t hi_en_q, hi_en_d;
    pns_byte_t trig_q, trig_d;
    pns_byte_t pa_q, pa_d;
    pns_byte_t pb_q, pb_d;
    pns_word_t prdata_q, prdata_d;
    logic      pready_q, pready_d;
    logic      pslverr_q, pslverr_d;
    logic      standby_s1_q, standby_q;
    logic [3:0] fire;
    logic       shared_hi;
    logic       wr, rd, bus_access;
    logic       hit;
    pns_byte_t  rsel;
    pns_byte_t  wbyte;

    // Two-flop synchroniser for the standby pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_s1_q <= 1'b0;
            standby_q    <= 1'b0;
        end else begin
            standby_s1_q <= hw_standby;
            standby_q    <= standby_s1_q;
        end
    end

    // Match strobes come from timer logic on this clock, so they are used
    // directly: the copy lands on the edge right after the strobe

    // Per-group trigger decode from the select fields
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_fire
            assign fire[g] = match_strobe[trig_q[2*g+1 -: 2]]; // [RQ18] [RQ19]
        end
    endgenerate

    assign shared_hi  = (trig_q[7:6] == trig_q[5:4]);
    assign bus_access = psel && penable && !pready_q;
    // Writes commit at the edge where the master samples pready high
    assign wr         = psel && penable && pready_q && pwrite;
    assign rd         = bus_access && !pwrite;
    assign wbyte      = pwdata[7:0];

    always_comb begin
        hit  = 1'b1;
        rsel = 8'h00;
        case (paddr)
            `PNS_OFF_NEXT_HI: begin
                if (shared_hi) begin
                    rsel = upper_next_q; // [RQ1] [RQ4]
                end else begin
                    rsel = {upper_next_q[7:4], 4'hf}; // [RQ6] [RQ7]
                end
            end
            `PNS_OFF_NEXT_HI_ALT: begin
                if (shared_hi) begin
                    rsel = `PNS_RSVD; // [RQ5]
                end else begin
                    rsel = {4'hf, upper_next_q[3:0]}; // [RQ6] [RQ7]
                end
            end
            `PNS_OFF_EN_LO:  rsel = lo_en_q; // [RQ8]
            `PNS_OFF_EN_HI:  rsel = hi_en_q; // [RQ12]
            `PNS_OFF_TRIG:   rsel = trig_q;
            `PNS_OFF_PORT:   rsel = pb_q;
            default:         hit  = 1'b0;
        endcase
    end

    always_comb begin
        upper_next_d = upper_next_q;
        lo_en_d      = lo_en_q;
        hi_en_d      = hi_en_q;
        trig_d       = trig_q;
        pa_d         = pa_q;
        pb_d         = pb_q;
        prdata_d     = prdata_q;
        pready_d     = bus_access;
        pslverr_d    = bus_access && !hit;
        if (wr && pstrb[0]) begin
            case (paddr)
                `PNS_OFF_NEXT_HI: begin
                    if (shared_hi) begin
                        upper_next_d = wbyte; // [RQ4]
                    end else begin
                        upper_next_d[7:4] = wbyte[7:4]; // [RQ6] [RQ7]
                    end
                end
                `PNS_OFF_NEXT_HI_ALT: begin
                    if (!shared_hi) begin
                        upper_next_d[3:0] = wbyte[3:0]; // [RQ6] [RQ7]
                    end
                end
                `PNS_OFF_EN_LO: lo_en_d = wbyte; // [RQ8]
                `PNS_OFF_EN_HI: hi_en_d = wbyte; // [RQ12]
                `PNS_OFF_TRIG:  trig_d  = wbyte;
                `PNS_OFF_PORT: begin
                    pb_d = (pb_q & hi_en_q) | (wbyte & ~hi_en_q); // [RQ16]
                end
                default: ;
            endcase
        end
        if (rd) begin
            prdata_d = {24'h000000, rsel};
        end
        // Match transfers win over software port writes
        for (int i = 0; i < 8; i++) begin
            if (fire[i / 4] && lo_en_q[i]) begin
                pa_d[i] = lower_next_bits[i]; // [RQ9] [RQ10]
            end
            if (fire[2 + i / 4] && hi_en_q[i]) begin
                pb_d[i] = upper_next_q[i]; // [RQ2] [RQ13] [RQ14]
            end
        end
        if (standby_q) begin
            upper_next_d = `PNS_RST_NEXT; // [RQ3]
            lo_en_d      = `PNS_RST_EN; // [RQ11]
            hi_en_d      = `PNS_RST_EN; // [RQ15]
            trig_d       = `PNS_RST_TRIG;
            pa_d         = `PNS_RST_PORT;
            pb_d         = `PNS_RST_PORT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_next_q <= `PNS_RST_NEXT; // [RQ3]
            lo_en_q      <= `PNS_RST_EN; // [RQ11]
            hi_en_q      <= `PNS_RST_EN; // [RQ15]
            trig_q       <= `PNS_RST_TRIG;
            pa_q         <= `PNS_RST_PORT;
            pb_q         <= `PNS_RST_PORT;
            prdata_q     <= 32'h00000000;
            pready_q     <= 1'b0;
            pslverr_q    <= 1'b0;
        end else begin
            upper_next_q <= upper_next_d;
            lo_en_q      <= lo_en_d;
            hi_en_q      <= hi_en_d;
            trig_q       <= trig_d;
            pa_q         <= pa_d;
            pb_q         <= pb_d;
            prdata_q     <= prdata_d;
            pready_q     <= pready_d;
            pslverr_q    <= pslverr_d;
        end
    end

    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign prdata              = prdata_q;
    assign port_a_output_latch = pa_q;
    assign port_b_output_latch = pb_q;

    property p_disabled_b_holds;
        @(posedge pclk) disable iff (!presetn)
        (!standby_q && !wr && hi_en_q == 8'h00) |=> $stable(pb_q);
    endproperty
    a_disabled_b_holds: assert property (p_disabled_b_holds) // [RQ14]
        else $error("port b changed with all enables off");

    property p_disabled_a_holds;
        @(posedge pclk) disable iff (!presetn)
        (!standby_q && lo_en_q == 8'h00) |=> $stable(pa_q);
    endproperty
    a_disabled_a_holds: assert property (p_disabled_a_holds) // [RQ10]
        else $error("port a changed with all enables off");

    property p_b_copy;
        @(posedge pclk) disable iff (!presetn)
        (!standby_q && fire[2]) |=> ((pb_q[3:0] & $past(hi_en_q[3:0]))
            == ($past(upper_next_q[3:0]) & $past(hi_en_q[3:0])));
    endproperty
    a_b_copy: assert property (p_b_copy) // [RQ13] [RQ19]
        else $error("port b group 2 did not take next data");

    property p_b_copy_hi;
        @(posedge pclk) disable iff (!presetn)
        (!standby_q && fire[3]) |=> ((pb_q[7:4] & $past(hi_en_q[7:4]))
            == ($past(upper_next_q[7:4]) & $past(hi_en_q[7:4])));
    endproperty
    a_b_copy_hi: assert property (p_b_copy_hi) // [RQ2] [RQ19]
        else $error("port b group 3 did not take next data");

    property p_a_copy;
        @(posedge pclk) disable iff (!presetn)
        (!standby_q && fire[0]) |=> ((pa_q[3:0] & $past(lo_en_q[3:0]))
            == ($past(lower_next_bits[3:0]) & $past(lo_en_q[3:0])));
    endproperty
    a_a_copy: assert property (p_a_copy) // [RQ9]
        else $error("port a group 0 did not take next data");

    property p_a_copy_hi;
        @(posedge pclk) disable iff (!presetn)
        (!standby_q && fire[1]) |=> ((pa_q[7:4] & $past(lo_en_q[7:4]))
            == ($past(lower_next_bits[7:4]) & $past(lo_en_q[7:4])));
    endproperty
    a_a_copy_hi: assert property (p_a_copy_hi) // [RQ9] [RQ19]
        else $error("port a group 1 did not take next data");

    property p_group3_own;
        @(posedge pclk) disable iff (!presetn)
        (!standby_q && !fire[3] && !(wr && paddr == `PNS_OFF_PORT))
            |=> $stable(pb_q[7:4]);
    endproperty
    a_group3_own: assert property (p_group3_own) // [RQ18]
        else $error("group 3 moved without its own trigger");

    property p_group0_own;
        @(posedge pclk) disable iff (!presetn)
        (!standby_q && !fire[0]) |=> $stable(pa_q[3:0]);
    endproperty
    a_group0_own: assert property (p_group0_own) // [RQ18]
        else $error("group 0 moved without its own trigger");

    property p_standby_clear;
        @(posedge pclk) disable iff (!presetn)
        standby_q |=> (upper_next_q == 8'h00 && lo_en_q == 8'h00
                       && hi_en_q == 8'h00);
    endproperty
    a_standby_clear: assert property (p_standby_clear) // [RQ3]
        else $error("standby did not clear registers");

    property p_alt_reads_ones;
        @(posedge pclk) disable iff (!presetn)
        (rd && shared_hi && paddr == `PNS_OFF_NEXT_HI_ALT)
            |=> (prdata_q == 32'h000000ff);
    endproperty
    a_alt_reads_ones: assert property (p_alt_reads_ones) // [RQ5]
        else $error("reserved address did not read all ones");

    property p_sep_low_ones;
        @(posedge pclk) disable iff (!presetn)
        (rd && !shared_hi && paddr == `PNS_OFF_NEXT_HI)
            |=> (prdata_q[3:0] == 4'hf);
    endproperty
    a_sep_low_ones: assert property (p_sep_low_ones) // [RQ7]
        else $error("reserved nibble did not read as ones");

    property p_port_write_guard;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `PNS_OFF_PORT && fire[3:2] == 2'b00 && !standby_q)
            |=> ((pb_q & $past(hi_en_q)) == ($past(pb_q) & $past(hi_en_q)));
    endproperty
    a_port_write_guard: assert property (p_port_write_guard) // [RQ16]
        else $error("software changed an enabled port bit");

    property p_ready_once;
        @(posedge pclk) disable iff (!presetn)
        pready_q |=> !pready_q;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("pready held two cycles");

    c_b_transfer: cover property (@(posedge pclk) disable iff (!presetn)
        fire[3] && hi_en_q != 8'h00);
    c_a_transfer: cover property (@(posedge pclk) disable iff (!presetn)
        fire[0] && lo_en_q != 8'h00);
    c_sep_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr && !shared_hi && paddr == `PNS_OFF_NEXT_HI_ALT);
    c_standby: cover property (@(posedge pclk) disable iff (!presetn)
        standby_q);
    c_port_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `PNS_OFF_PORT && hi_en_q != 8'h00);
endmodule : pns_staging
`default_nettype wire

// ==== test/pns_timer_model.sv ====
// Timer compare-match model driving strobes and lower next data
`timescale 1ns/1ps
`default_nettype none
module pns_timer_model (
    input  wire logic       pclk,
    output logic      [3:0] match_strobe,
    output logic      [7:0] lower_next_bits
);
    initial begin
        match_strobe    = 4'h0;
        lower_next_bits = 8'h00;
    end
    // One-cycle strobe; lower data is held until the next event
    task automatic fire(input logic [1:0] idx, input logic [7:0] nd);
        lower_next_bits <= nd;
        match_strobe    <= 4'h1 << idx;
        @(posedge pclk);
        match_strobe    <= 4'h0;
    endtask : fire
endmodule : pns_timer_model
`default_nettype wire

// ==== test/pns_staging_tb.sv ====
// Self-checking bench for pattern next-data staging
`timescale 1ns/1ps
`default_nettype none
`include "pns_params.svh"
module pns_staging_tb;
    import pns_pkg::*;
    logic pclk = 0, presetn = 0, hw_standby = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, seed = 32'h1abc;
    logic pready, pslverr;
    logic [3:0] match_strobe;
    logic [7:0] lower_next_bits, r, nd;
    pns_word_t prdata;
    pns_byte_t pa, pb;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    int err_count = 0, compares = 0;
    always #4 pclk = ~pclk;
    pns_timer_model i_tmr (.pclk(pclk), .match_strobe(match_strobe),
        .lower_next_bits(lower_next_bits));
    pns_staging i_dut (.pclk(pclk), .presetn(presetn),
        .hw_standby(hw_standby), .match_strobe(match_strobe),
        .lower_next_bits(lower_next_bits), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
        .pslverr(pslverr), .prdata(prdata),
        .port_a_output_latch(pa), .port_b_output_latch(pb));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic final_report();
        if (exp_q.size() != 0) err_count++;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 20) begin
            $display("BAD %0t no pready", $time);
            err_count++;
            final_report();
        end
        // Idle edge so the next request never re-raises psel at once
        @(posedge pclk);
    endtask : apb
    // Read with expected data, or an expected slave error
    task automatic rd(input logic [11:0] a, input logic [7:0] x,
                      input logic er = 1'b0);
        exp_q.push_back({er, x});
        apb(1'b0, a, 8'h00);
    endtask : rd
    task automatic cmp_rd(input logic [8:0] x);
        compares++;
        if (pslverr !== x[8] || (!x[8] && prdata !== {24'h0, x[7:0]})) begin
            $display("BAD %0t read %h exp %h", $time, prdata, x[7:0]);
            err_count++;
        end
    endtask : cmp_rd
    task automatic cmp_port(input pns_byte_t g, input pns_byte_t x);
        compares++;
        if (g !== x) begin
            $display("BAD %0t port %h exp %h", $time, g, x);
            err_count++;
        end
    endtask : cmp_port
    task automatic fire(input logic [1:0] i, input logic [7:0] d);
        i_tmr.fire(i, d);
        repeat (4) @(posedge pclk);
    endtask : fire
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                $display("BAD %0t unexpected read", $time);
                err_count++;
            end else begin
                e = exp_q.pop_front();
                cmp_rd(e);
            end
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`PNS_OFF_NEXT_HI, `PNS_RST_NEXT);
        rd(`PNS_OFF_EN_LO, `PNS_RST_EN);
        rd(`PNS_OFF_EN_HI, `PNS_RST_EN);
        rd(`PNS_OFF_TRIG, `PNS_RST_TRIG);
        rd(`PNS_OFF_PORT, `PNS_RST_PORT);
        seed = lfsr(seed); r = seed[7:0];
        apb(1'b1, `PNS_OFF_NEXT_HI, r);
        apb(1'b1, `PNS_OFF_NEXT_HI_ALT, ~r);
        rd(`PNS_OFF_NEXT_HI_ALT, `PNS_RSVD);
        rd(`PNS_OFF_NEXT_HI, r);
        rd(12'h010, 8'h00, 1'b1);
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed); r = seed[7:0];
            apb(1'b1, k ? `PNS_OFF_EN_HI : `PNS_OFF_EN_LO, r);
            rd(k ? `PNS_OFF_EN_HI : `PNS_OFF_EN_LO, r);
        end
        apb(1'b1, `PNS_OFF_TRIG, 8'he4);
        apb(1'b1, `PNS_OFF_NEXT_HI, 8'h5a);
        apb(1'b1, `PNS_OFF_NEXT_HI_ALT, 8'h3c);
        rd(`PNS_OFF_NEXT_HI, 8'h5f);
        rd(`PNS_OFF_NEXT_HI_ALT, 8'hfc);
        apb(1'b1, `PNS_OFF_EN_LO, 8'h0f);
        // Far side: port B pins of enabled bits are taken as outputs
        apb(1'b1, `PNS_OFF_EN_HI, 8'hf0);
        seed = lfsr(seed); nd = seed[7:0];
        fire(2'd0, nd);
        cmp_port(pa, {4'h0, nd[3:0]});
        fire(2'd1, ~nd);
        cmp_port(pa, {4'h0, nd[3:0]});
        fire(2'd3, 8'h00);
        cmp_port(pb, 8'h50);
        apb(1'b1, `PNS_OFF_PORT, 8'hff);
        rd(`PNS_OFF_PORT, 8'h5f);
        fire(2'd2, 8'h00);
        cmp_port(pb, 8'h5f);
        apb(1'b1, `PNS_OFF_EN_HI, 8'hff);
        fire(2'd2, 8'h00);
        cmp_port(pb, 8'h5c);
        hw_standby <= 1'b1;
        repeat (4) @(posedge pclk);
        hw_standby <= 1'b0;
        repeat (4) @(posedge pclk);
        cmp_port(pa, 8'h00);
        rd(`PNS_OFF_NEXT_HI, `PNS_RST_NEXT);
        rd(`PNS_OFF_EN_LO, `PNS_RST_EN);
        rd(`PNS_OFF_EN_HI, `PNS_RST_EN);
        repeat (3) @(posedge pclk);
        final_report();
    end
endmodule : pns_staging_tb
`default_nettype wire
